// ==== pws_pkg.sv ====
// Constants and types shared by the power waveform sequencer files.
package pws_pkg;

    // ------------------------------------------------------------------
    // Program record layout
    // ------------------------------------------------------------------
    localparam int CODE_W   = 8;
    localparam int P1_W     = 16;
    localparam int P2_W     = 32;
    localparam int REC_W    = CODE_W + P1_W + P2_W;
    localparam int CODE_LSB = P1_W + P2_W;
    localparam int P1_LSB   = P2_W;
    localparam int P2_LSB   = 0;
    localparam int PWR_W    = 16;

    // ------------------------------------------------------------------
    // Command codes and selectors
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] CMD_STOP     = 8'h01;
    localparam logic [CODE_W-1:0] CMD_TIMED    = 8'h02;
    localparam logic [CODE_W-1:0] CMD_RATE     = 8'h03;
    localparam logic [CODE_W-1:0] CMD_WAIT     = 8'h04;
    localparam logic [CODE_W-1:0] CMD_GOTO     = 8'h05;
    localparam logic [CODE_W-1:0] CMD_SYNC_OUT = 8'h06;

    localparam logic [P1_W-1:0] WAIT_LOW   = 16'h0001;
    localparam logic [P1_W-1:0] WAIT_HIGH  = 16'h0002;
    localparam logic [P1_W-1:0] WAIT_RISE  = 16'h0003;
    localparam logic [P1_W-1:0] WAIT_FALL  = 16'h0004;
    localparam logic [P1_W-1:0] WAIT_TIMER = 16'h0005;

    localparam logic [P2_W-1:0] GOTO_IF_LOW  = 32'hFFFFFFFF;
    localparam logic [P2_W-1:0] GOTO_IF_HIGH = 32'hFFFFFFFE;
    localparam logic [P2_W-1:0] GOTO_MAX_MS  = 32'h000F4240;

    localparam logic [P2_W-1:0] SYNC_DRIVE_LOW  = 32'h00000001;
    localparam logic [P2_W-1:0] SYNC_DRIVE_HIGH = 32'h00000002;

    // ------------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int PROG_DEPTH    = 100;

    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_DECODE, S_RAMP_T, S_RAMP_R,
        S_WAIT_LVL, S_WAIT_EDGE, S_WAIT_MS, S_GOTO_WAIT
    } seq_state_t;

endpackage

// ==== prog_if.sv ====
// Read and load port between the sequencer and its program store.
interface prog_if
    import pws_pkg::*;
#(
    parameter int AW = 7
);
    logic [AW-1:0]    rd_addr;
    logic [REC_W-1:0] rd_data;
    logic             wr_en;
    logic [AW-1:0]    wr_addr;
    logic [REC_W-1:0] wr_data;

    modport mem (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
    modport seq (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
endinterface

// ==== pws_prog_mem.sv ====
// Program record store with a registered read port.
module pws_prog_mem
    import pws_pkg::*;
#(
    parameter int DEPTH = PROG_DEPTH,
    parameter int AW    = 7
)
(
    input wire logic i_ref_clk,
    prog_if.mem      bus
);
    typedef struct packed {
        logic [REC_W-1:0] rd_data;
    } mem_state_t;

    logic [REC_W-1:0] mem_q [DEPTH];
    mem_state_t       q;
    mem_state_t       d;

    always_comb
    begin
        d = q;
        d.rd_data = mem_q[bus.rd_addr];
    end

    always_ff @(posedge i_ref_clk)
    begin
        q <= d;
        if (bus.wr_en)
        begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
    end

    assign bus.rd_data = q.rd_data;
endmodule

// ==== power_waveform_sequencer.sv ====
// Stored-program sequencer that shapes output power from command records.
// Functional notes
// - Record is code byte, two-byte parameter one, four-byte parameter two.
// - Code 1 ends execution; every program must end with it.
// - Code 2 ramps power to parameter two over parameter one ms.
// - Code 3 ramps power to parameter two at parameter one W per ms.
// - Code 4 selector 1 or 2 waits for sync input low or high.
// - Code 4 selector 3 or 4 waits for sync rising or falling edge.
// - Code 5 with -1 jumps to line parameter one if sync low.
// - Code 5 with -2 jumps to line parameter one if sync high.
// - Code 5 with 0 to 1000000 jumps after that many ms.
module power_waveform_sequencer
    import pws_pkg::*;
#(
    parameter int DEPTH   = PROG_DEPTH,
    parameter int MS_CYC  = MS_CYCLES
)
(
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_start,
    input  wire logic             i_sync_in,
    input  wire logic             i_load_en,
    input  wire logic [6:0]       i_load_line,
    input  wire logic [REC_W-1:0] i_load_rec,
    output logic [PWR_W-1:0]      o_power,
    output logic                  o_sync_out,
    output logic                  o_busy,
    output logic                  o_fault,
    output logic [6:0]            o_line
);
    localparam int AW     = 7;
    localparam int TICK_W = $clog2(MS_CYC);
    localparam int DEN_W  = P1_W + TICK_W;

    if (MS_CYC < 2 || DEPTH < 2 || DEPTH > (1 << AW))
    begin : g_bad_param
        $error("Unsupported sequencer parameters.");
    end

    function automatic logic [CODE_W-1:0] f_code(logic [REC_W-1:0] r);
        return r[CODE_LSB +: CODE_W];
    endfunction
    function automatic logic [P1_W-1:0] f_p1(logic [REC_W-1:0] r);
        return r[P1_LSB +: P1_W];
    endfunction
    function automatic logic [P2_W-1:0] f_p2(logic [REC_W-1:0] r);
        return r[P2_LSB +: P2_W];
    endfunction

    typedef struct packed {
        seq_state_t        st;
        logic [AW-1:0]     pc;
        logic [P1_W-1:0]   p1;
        logic [P2_W-1:0]   p2;
        logic [PWR_W-1:0]  power;
        logic [PWR_W-1:0]  target;
        logic              up;
        logic [PWR_W-1:0]  delta;
        logic [DEN_W-1:0]  denom;
        logic [DEN_W-1:0]  acc;
        logic [TICK_W-1:0] tick;
        logic [P2_W-1:0]   dur;
        logic              sync_prev;
        logic              sync_out;
        logic              busy;
        logic              fault;
    } seq_q_t;

    seq_q_t q;
    seq_q_t d;

    prog_if #(.AW(AW)) pif ();

    pws_prog_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem
    (
        .i_ref_clk (i_ref_clk),
        .bus       (pif.mem)
    );

    assign pif.rd_addr = q.pc;
    assign pif.wr_en   = i_load_en;
    assign pif.wr_addr = i_load_line;
    assign pif.wr_data = i_load_rec;

    logic [CODE_W-1:0] rd_code;
    logic [P1_W-1:0]   rd_p1;
    logic [P2_W-1:0]   rd_p2;
    logic              ms_tick;

    assign rd_code = f_code(pif.rd_data);
    assign rd_p1   = f_p1(pif.rd_data);
    assign rd_p2   = f_p2(pif.rd_data);
    assign ms_tick = (q.tick == TICK_W'(MS_CYC - 1));

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    always_comb
    begin
        logic             go_adv;
        logic             go_jump;
        logic             go_fault;
        logic [P1_W-1:0]  jump_line;
        logic [DEN_W:0]   acc_n;
        logic [PWR_W-1:0] gap;
        go_adv    = 1'b0;
        go_jump   = 1'b0;
        go_fault  = 1'b0;
        jump_line = q.p1;
        acc_n     = '0;
        gap       = q.up ? q.target - q.power : q.power - q.target;
        d           = q;
        d.sync_prev = i_sync_in;
        d.tick      = ms_tick ? '0 : q.tick + 1'b1;
        unique case (q.st)
            S_IDLE:
            begin
                if (i_start)
                begin
                    d.pc    = '0;
                    d.st    = S_FETCH;
                    d.busy  = 1'b1;
                    d.fault = 1'b0;
                end
            end
            S_FETCH:
                d.st = S_DECODE;
            S_DECODE:
            begin
                d.p1      = rd_p1;
                d.p2      = rd_p2;
                d.tick    = '0;
                d.acc     = '0;
                d.target  = rd_p2[PWR_W-1:0];
                d.up      = rd_p2[PWR_W-1:0] >= q.power;
                d.delta   = d.up ? d.target - q.power : q.power - d.target;
                d.denom   = DEN_W'(rd_p1) * DEN_W'(MS_CYC);
                d.dur     = rd_p2;
                jump_line = rd_p1;
                case (rd_code)
                    CMD_STOP:
                    begin
                        d.st   = S_IDLE;
                        d.busy = 1'b0;
                    end
                    CMD_TIMED, CMD_RATE:
                    begin
                        if (rd_p1 == '0)
                        begin
                            d.power = d.target;
                            go_adv  = 1'b1;
                        end
                        else
                        begin
                            d.st = (rd_code == CMD_TIMED) ? S_RAMP_T : S_RAMP_R;
                        end
                    end
                    CMD_WAIT:
                    begin
                        case (rd_p1)
                            WAIT_LOW, WAIT_HIGH:   d.st = S_WAIT_LVL;
                            WAIT_RISE, WAIT_FALL:  d.st = S_WAIT_EDGE;
                            WAIT_TIMER:            d.st = S_WAIT_MS;
                            default:               go_fault = 1'b1;
                        endcase
                    end
                    CMD_GOTO:
                    begin
                        if (rd_p2 == GOTO_IF_LOW)
                        begin
                            go_jump = !i_sync_in;
                            go_adv  = i_sync_in;
                        end
                        else if (rd_p2 == GOTO_IF_HIGH)
                        begin
                            go_jump = i_sync_in;
                            go_adv  = !i_sync_in;
                        end
                        else if (rd_p2 <= GOTO_MAX_MS)
                        begin
                            d.st = S_GOTO_WAIT;
                        end
                        else
                        begin
                            go_fault = 1'b1;
                        end
                    end
                    CMD_SYNC_OUT:
                    begin
                        if (rd_p2 == SYNC_DRIVE_LOW || rd_p2 == SYNC_DRIVE_HIGH)
                        begin
                            d.sync_out = (rd_p2 == SYNC_DRIVE_HIGH);
                            go_adv     = 1'b1;
                        end
                        else
                        begin
                            go_fault = 1'b1;
                        end
                    end
                    default:
                        go_fault = 1'b1;
                endcase
            end
            S_RAMP_T:
            begin
                // One watt per step, spread evenly over the duration.
                acc_n = {1'b0, q.acc} + (DEN_W + 1)'(q.delta);
                if (q.power == q.target)
                begin
                    go_adv = 1'b1;
                end
                else if (acc_n >= {1'b0, q.denom})
                begin
                    d.acc   = DEN_W'(acc_n - {1'b0, q.denom});
                    d.power = q.up ? q.power + 1'b1 : q.power - 1'b1;
                end
                else
                begin
                    d.acc = DEN_W'(acc_n);
                end
            end
            S_RAMP_R:
            begin
                if (q.power == q.target)
                begin
                    go_adv = 1'b1;
                end
                else if (ms_tick)
                begin
                    if (gap <= q.p1)
                    begin
                        d.power = q.target;
                    end
                    else
                    begin
                        d.power = q.up ? q.power + q.p1 : q.power - q.p1;
                    end
                end
            end
            S_WAIT_LVL:
                go_adv = (q.p1 == WAIT_LOW) ? !i_sync_in : i_sync_in;
            S_WAIT_EDGE:
                go_adv = (q.p1 == WAIT_RISE) ? (i_sync_in && !q.sync_prev)
                                             : (!i_sync_in && q.sync_prev);
            S_WAIT_MS, S_GOTO_WAIT:
            begin
                if (q.dur == '0)
                begin
                    go_adv  = (q.st == S_WAIT_MS);
                    go_jump = (q.st == S_GOTO_WAIT);
                end
                else if (ms_tick)
                begin
                    d.dur = q.dur - 1'b1;
                end
            end
        endcase
        if (go_adv)
        begin
            go_fault = (q.pc == AW'(DEPTH - 1));
            d.pc     = q.pc + 1'b1;
            d.st     = S_FETCH;
        end
        if (go_jump)
        begin
            go_fault = (jump_line >= P1_W'(DEPTH));
            d.pc     = jump_line[AW-1:0];
            d.st     = S_FETCH;
        end
        if (go_fault)
        begin
            d.st    = S_IDLE;
            d.busy  = 1'b0;
            d.fault = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_power    = q.power;
    assign o_sync_out = q.sync_out;
    assign o_busy     = q.busy;
    assign o_fault    = q.fault;
    assign o_line     = q.pc;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    logic in_dec;
    assign in_dec = (q.st == S_DECODE);

    property p_rec_fields;
        in_dec && rd_code == CMD_GOTO |=> q.p1 == $past(rd_p1)
                                         && q.p2 == $past(rd_p2);
    endproperty
    a_rec_fields: assert property (p_rec_fields) else $error("Fields bad.");

    property p_stop;
        in_dec && rd_code == CMD_STOP |=> q.st == S_IDLE && !o_busy ##1 !o_busy;
    endproperty
    a_stop: assert property (p_stop) else $error("Stop not taken.");

    property p_timed_step;
        q.st == S_RAMP_T |=> (o_power - $past(o_power) <= 16'h0001)
                          || ($past(o_power) - o_power <= 16'h0001);
    endproperty
    a_timed_step: assert property (p_timed_step) else $error("Ramp jump.");

    property p_rate_tick;
        q.st == S_RAMP_R && !ms_tick |=> $stable(o_power);
    endproperty
    a_rate_tick: assert property (p_rate_tick) else $error("Rate off tick.");

    property p_level_hold;
        q.st == S_WAIT_LVL && q.p1 == WAIT_LOW && i_sync_in |=> q.st == S_WAIT_LVL;
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("Left wait.");

    property p_rise;
        q.st == S_WAIT_EDGE && q.p1 == WAIT_RISE && i_sync_in && !q.sync_prev
            |=> q.st == S_FETCH ##1 q.st == S_DECODE;
    endproperty
    a_rise: assert property (p_rise) else $error("Edge missed.");

    property p_goto_low;
        in_dec && rd_code == CMD_GOTO && rd_p2 == GOTO_IF_LOW && !i_sync_in
            && rd_p1 < P1_W'(DEPTH) |=> o_line == $past(rd_p1[AW-1:0]);
    endproperty
    a_goto_low: assert property (p_goto_low) else $error("Jump low.");

    property p_goto_high;
        in_dec && rd_code == CMD_GOTO && rd_p2 == GOTO_IF_HIGH && !i_sync_in
            && q.pc != AW'(DEPTH - 1) |=> o_line == $past(q.pc) + 1'b1;
    endproperty
    a_goto_high: assert property (p_goto_high) else $error("Jump high.");

    property p_goto_timer;
        q.st == S_GOTO_WAIT && q.dur != '0 |=> q.st == S_GOTO_WAIT;
    endproperty
    a_goto_timer: assert property (p_goto_timer) else $error("Early jump.");

    property p_pause;
        q.st == S_WAIT_MS && q.dur == '0 && q.pc != AW'(DEPTH - 1)
            |=> q.st == S_FETCH && o_line == $past(q.pc) + 1'b1;
    endproperty
    a_pause: assert property (p_pause) else $error("Pause end.");

    property p_sync_out;
        in_dec && rd_code == CMD_SYNC_OUT && rd_p2 == SYNC_DRIVE_HIGH
            |=> o_sync_out;
    endproperty
    a_sync_out: assert property (p_sync_out) else $error("Sync out.");

    c_timed: cover property (q.st == S_RAMP_T ##1 q.st == S_FETCH);
    c_edge:  cover property (q.st == S_WAIT_EDGE ##1 q.st == S_FETCH);
    c_jump:  cover property (q.st == S_GOTO_WAIT ##1 q.st == S_FETCH);
    c_stop:  cover property (in_dec && rd_code == CMD_STOP);
endmodule

// ==== sync_ctrl_model.sv ====
// Behavioural external controller that drives the block's sync input.
module sync_ctrl_model
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_echo,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_level,
    input  wire logic       i_sync_from_dev,
    output logic            o_sync_to_dev
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] hist_q = 16'h0000;

    initial o_sync_to_dev = 1'b0;

    // In echo mode the controller answers the block's sync output after a
    // chosen number of cycles, so both prompt and slow replies are seen.
    always @(posedge i_ref_clk)
    begin
        hist_q        <= {hist_q[14:0], i_sync_from_dev};
        o_sync_to_dev <= i_echo ? hist_q[i_delay] : i_level;
    end
endmodule

// ==== power_waveform_sequencer_tb.sv ====
// Self-checking testbench for the power waveform sequencer.
module power_waveform_sequencer_tb
    import pws_pkg::*;
    ();
    timeunit 1ns;
    timeprecision 1ns;

    localparam int MS_C  = 10;
    localparam int LIMIT = 6000;

    logic             i_ref_clk;
    logic             rst_b;
    logic             start;
    logic             sync_in;
    logic             load_en;
    logic [6:0]       load_line;
    logic [REC_W-1:0] load_rec;
    logic [PWR_W-1:0] power;
    logic             sync_out;
    logic             busy;
    logic             fault;
    logic [6:0]       line;
    logic             echo;
    logic [3:0]       delay;
    logic             level;
    int               bad_count;
    int               n_compared;
    int               cycles;

    power_waveform_sequencer #(.MS_CYC(MS_C)) dut_u (
        .i_ref_clk  (i_ref_clk),
        .i_rst_b    (rst_b),
        .i_start    (start),
        .i_sync_in  (sync_in),
        .i_load_en  (load_en),
        .i_load_line(load_line),
        .i_load_rec (load_rec),
        .o_power    (power),
        .o_sync_out (sync_out),
        .o_busy     (busy),
        .o_fault    (fault),
        .o_line     (line)
    );

    sync_ctrl_model ctrl_u (
        .i_ref_clk      (i_ref_clk),
        .i_echo         (echo),
        .i_delay        (delay),
        .i_level        (level),
        .i_sync_from_dev(sync_out),
        .o_sync_to_dev  (sync_in)
    );

    initial
    begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    // The write strobe stays high between records and is lowered by run.
    task automatic load(input logic [6:0] ln, input logic [7:0] code,
                        input logic [15:0] p1, input logic [31:0] p2);
        load_en   = 1'b1;
        load_line = ln;
        load_rec  = {code, p1, p2};
        step(1);
    endtask

    task automatic run();
        load_en = 1'b0;
        start   = 1'b1;
        step(1);
        start   = 1'b0;
    endtask

    task automatic wait_done(input int lim, output int n);
        n = 0;
        while (busy !== 1'b0 && n < lim)
        begin
            step(1);
            n++;
        end
        chk(n < lim, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_ramps();
        int n;
        load(7'h00, CMD_TIMED, 16'h0, 32'h0);
        load(7'h01, CMD_TIMED, 16'h2, 32'h14);
        load(7'h02, CMD_STOP, 16'h0, 32'h0);
        run();
        step(8);
        chk(power < 16'h14, 1'b1);
        wait_done(100, n);
        chk(power, 32'h14);
        chk(n >= 16 && n <= 24, 1'b1);
        chk(line, 32'h2);
        load(7'h00, CMD_TIMED, 16'h0, 32'h14);
        load(7'h01, CMD_RATE, 16'h4, 32'h5);
        run();
        step(20);
        chk(power, 32'h10);
        wait_done(100, n);
        chk(power, 32'h5);
        chk(n >= 20 && n <= 32, 1'b1);
    endtask

    task automatic sc_waits();
        int n;
        logic lvl;
        for (int s = 1; s <= 4; s++)
        begin
            lvl   = (s == 1 || s == 4);
            level = lvl;
            step(3);
            load(7'h00, CMD_WAIT, 16'(s), 32'h0);
            load(7'h01, CMD_STOP, 16'h0, 32'h0);
            run();
            step(20);
            chk(busy, 1'b1);
            chk(line, 32'h0);
            level = ~lvl;
            wait_done(20, n);
            chk(line, 32'h1);
        end
        load(7'h00, CMD_WAIT, WAIT_TIMER, 32'h3);
        load(7'h01, CMD_STOP, 16'h0, 32'h0);
        run();
        step(25);
        chk(busy, 1'b1);
        wait_done(30, n);
        chk(line, 32'h1);
    endtask

    task automatic sc_goto(input logic [31:0] p2, input logic s,
                           input logic jump);
        int n;
        level = s;
        step(3);
        load(7'h00, CMD_GOTO, 16'h3, p2);
        load(7'h01, CMD_TIMED, 16'h0, 32'h11);
        load(7'h02, CMD_STOP, 16'h0, 32'h0);
        load(7'h03, CMD_TIMED, 16'h0, 32'h22);
        load(7'h04, CMD_STOP, 16'h0, 32'h0);
        run();
        wait_done(100, n);
        chk(power, jump ? 32'h22 : 32'h11);
        chk(line, jump ? 32'h4 : 32'h2);
        if (p2 == 32'h2)
            chk(n >= 20, 1'b1);
    endtask

    task automatic sc_sync_out(input logic [3:0] d);
        int n;
        echo  = 1'b1;
        delay = d;
        step(16);
        load(7'h00, CMD_SYNC_OUT, 16'h0, SYNC_DRIVE_HIGH);
        load(7'h01, CMD_WAIT, WAIT_HIGH, 32'h0);
        load(7'h02, CMD_SYNC_OUT, 16'h0, SYNC_DRIVE_LOW);
        load(7'h03, CMD_WAIT, WAIT_LOW, 32'h0);
        load(7'h04, CMD_STOP, 16'h0, 32'h0);
        run();
        step(2);
        chk(sync_out, 1'b1);
        wait_done(80, n);
        chk(sync_out, 1'b0);
        chk(line, 32'h4);
        echo = 1'b0;
    endtask

    task automatic sc_fault();
        int n;
        load(7'h00, 8'h07, 16'h0, 32'h0);
        run();
        wait_done(20, n);
        chk(fault, 1'b1);
        load(7'h00, CMD_STOP, 16'h0, 32'h0);
        run();
        wait_done(20, n);
        chk(fault, 1'b0);
        chk(line, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst_b     = 1'b0;
        start     = 1'b0;
        load_en   = 1'b0;
        load_line = 7'h00;
        load_rec  = '0;
        echo      = 1'b0;
        delay     = 4'h0;
        level     = 1'b0;
        step(16);
        chk({power, sync_out, busy, fault, line}, 32'h0);
        rst_b = 1'b1;
        sc_ramps();
        sc_waits();
        sc_goto(GOTO_IF_LOW, 1'b0, 1'b1);
        sc_goto(GOTO_IF_LOW, 1'b1, 1'b0);
        sc_goto(GOTO_IF_HIGH, 1'b1, 1'b1);
        sc_goto(GOTO_IF_HIGH, 1'b0, 1'b0);
        sc_goto(32'h2, 1'b0, 1'b1);
        sc_sync_out(4'h0);
        sc_sync_out(4'hC);
        sc_fault();
        stop_test();
    end
endmodule
